// File: bench/nand_flash_host_pin_interface_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module nand_flash_host_pin_interface_tb_top;
  import nfhc_pkg::*;
  logic clk, rst_n, cyc, stb, we, supply_low;
  logic [7:0] adr, b;
  logic [31:0] dat, rd;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, cle_o, ale_o, chip_sel_n_o, write_strobe_n_o, read_strobe_n_o;
  logic write_protect_n_o, volatile_protect_input_o, shared_bus_lines_oe_o, dev_busy;
  logic [7:0] host_bus, dev_bus, bus_in;
  int errors = 0;
  int compares = 0;
  assign bus_in = shared_bus_lines_oe_o ? host_bus : dev_bus;
  nfhc_host dut (.core_clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cle_o(cle_o), .ale_o(ale_o), .chip_sel_n_o(chip_sel_n_o), .write_strobe_n_o(write_strobe_n_o),
    .read_strobe_n_o(read_strobe_n_o), .write_protect_n_o(write_protect_n_o),
    .volatile_protect_input_o(volatile_protect_input_o), .shared_bus_lines_i(bus_in),
    .shared_bus_lines_o(host_bus), .shared_bus_lines_oe_o(shared_bus_lines_oe_o),
    .ready_i(!dev_busy), .supply_low_i(supply_low));
  nfhc_dev_model dev (.clk_i(clk), .rst_n_i(rst_n), .cle_i(cle_o), .ale_i(ale_o),
    .chip_sel_n_i(chip_sel_n_o), .write_strobe_n_i(write_strobe_n_o), .read_strobe_n_i(read_strobe_n_o),
    .write_protect_n_i(write_protect_n_o), .volatile_protect_input_i(volatile_protect_input_o),
    .host_oe_i(shared_bus_lines_oe_o), .bus_i(bus_in), .bus_o(dev_bus), .busy_o(dev_busy));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task give_verdict;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack is seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 300);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 300)
    begin
      errors++;
      $display("[ERR] t=%0t ack=%h exp=%h", $time, 1'b0, 1'b1);
      give_verdict;
    end
  endtask
  task op(input logic [1:0] k, input logic [7:0] v);
    wb(1'b1, REG_OP, {22'h0, k, v});
  endtask
  task automatic wait_idle;
    int n = 0;
    do
    begin
      wb(1'b0, REG_STAT, 32'h0);
      n++;
    end while (rd[ST_BUSY] !== 1'b0 && n < 100);
    if (n >= 100)
    begin
      errors++;
      $display("[ERR] t=%0t busy=%h exp=%h", $time, 1'b1, 1'b0);
      give_verdict;
    end
  endtask
  initial
  begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat = 32'h0;
    supply_low = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    chk({write_protect_n_o, volatile_protect_input_o}, 32'h0);
    chk(dev.prot_q, 32'h0);
    wb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    op(OP_CMD, 8'h00);
    wb(1'b0, REG_STAT, 32'h0);
    chk(rd[ST_ERR], 32'h1);
    chk(dev.ncmd, 32'h0);
    wb(1'b1, REG_STAT, 32'h10);
    op(OP_CMD, CMD_RESET);
    wait_idle;
    chk(dev.last_cmd, CMD_RESET);
    chk({rd[ST_RSTD], rd[ST_ERR]}, 32'h2);
    for (b = 8'h11; b < 8'h16; b++) op(OP_ADDR, b);
    wait_idle;
    chk(rd[10:8], 32'h5);
    chk({dev.addr_q[0], dev.addr_q[4]}, 32'h1115);
    chk(dev.plane, 32'h0);
    op(OP_DATA, 8'h5a);
    wait_idle;
    chk(dev.last_data, 32'h5a);
    // third read stalls until the first REG_RXD read frees a slot in the two-entry buffer
    repeat (3) op(OP_READ, 8'h00);
    wb(1'b0, REG_RXD, 32'h0);
    chk(rd, 32'h1a0);
    wb(1'b0, REG_RXD, 32'h0);
    chk(rd, 32'h1a1);
    wait_idle;
    wb(1'b0, REG_RXD, 32'h0);
    chk(rd, 32'h1a2);
    wb(1'b0, REG_RXD, 32'h0);
    chk(rd, 32'h0);
    chk({chip_sel_n_o, shared_bus_lines_oe_o, read_strobe_n_o}, 32'h5);
    wb(1'b1, REG_CTRL, 32'h3);
    chk({write_protect_n_o, volatile_protect_input_o}, 32'h3);
    op(OP_CMD, 8'h10);
    op(OP_CMD, CMD_STATUS);
    op(OP_ADDR, 8'h33);
    wait_idle;
    chk(dev.nprog, 32'h1);
    chk({dev.last_cmd, dev.addr_q[0]}, {16'h0, CMD_STATUS, 8'h33});
    wb(1'b1, REG_CTRL, 32'h0);
    supply_low <= 1'b1;
    op(OP_CMD, CMD_RESET);
    wb(1'b0, REG_STAT, 32'h0);
    chk(rd[ST_ERR], 32'h1);
    chk(dev.ncmd, 32'h3);
    chk(dev.viol, 32'h0);
    give_verdict;
  end
endmodule
`default_nettype wire

// File: bench/nfhc_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module nfhc_dev_model
  import nfhc_pkg::*;
#(
  parameter int unsigned BUSY_CYC = 30
)(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cle_i,
  input wire logic ale_i,
  input wire logic chip_sel_n_i,
  input wire logic write_strobe_n_i,
  input wire logic read_strobe_n_i,
  input wire logic write_protect_n_i,
  input wire logic volatile_protect_input_i,
  input wire logic host_oe_i,
  input wire logic [7:0] bus_i,
  output logic [7:0] bus_o,
  output logic busy_o
);
  logic [7:0] last_cmd = 8'h00;
  logic [7:0] last_data = 8'h00;
  logic [7:0] rd_byte = 8'h00;
  logic [7:0] addr_q [5];
  int ncmd = 0;
  int nprog = 0;
  int acnt = 0;
  int col = 0;
  int viol = 0;
  int busy_cnt = 0;
  logic hold_q;
  logic prot_q;
  logic plane = 1'b1;
  // latch a strobed byte by the latch strobes
  always @(posedge write_strobe_n_i)
  begin
    // the strobe's reset rise at time zero is not a host write
    if (!rst_n_i) last_data = 8'h00;
    else if (chip_sel_n_i || !host_oe_i) viol++;
    else if (busy_o && !(cle_i && (bus_i == CMD_RESET || bus_i == CMD_STATUS || bus_i == CMD_STATUS_ENH)))
      viol++;
    else if (cle_i)
    begin
      last_cmd = bus_i;
      ncmd++;
      if (bus_i == 8'h10 && write_protect_n_i)
      begin
        nprog++;
        busy_cnt = BUSY_CYC;
      end
    end
    else if (ale_i)
    begin
      addr_q[acnt % 5] = bus_i;
      if (acnt % 5 == 2) plane = bus_i[6];
      acnt++;
      col = 0;
    end
    else last_data = bus_i;
  end
  always @(negedge read_strobe_n_i)
  begin
    if (!chip_sel_n_i)
    begin
      rd_byte = 8'ha0 + col[7:0];
      col = (col + 1) % (PAGE_MAIN + PAGE_SPARE);
    end
  end
  // data held one clock past the read strobe's rise, then driven inverted
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hold_q <= 1'b0;
      prot_q <= volatile_protect_input_i;
    end
    else
    begin
      hold_q <= !read_strobe_n_i && !chip_sel_n_i;
      if (busy_cnt > 0) busy_cnt--;
    end
  end
  assign busy_o = busy_cnt != 0;
  assign bus_o = ((!read_strobe_n_i && !chip_sel_n_i) || hold_q) ? rd_byte : ~rd_byte;
endmodule
`default_nettype wire

// File: design/nfhc_host.sv
`timescale 1ns/1ps
`default_nettype none
module nfhc_host
  import nfhc_pkg::*;
#(
  parameter int unsigned DATA_W = 8,
  parameter int unsigned BUF_DEPTH = 2
)(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic cle_o,
  output logic ale_o,
  output logic chip_sel_n_o,
  output logic write_strobe_n_o,
  output logic read_strobe_n_o,
  output logic write_protect_n_o,
  output logic volatile_protect_input_o,
  input wire logic [DATA_W-1:0] shared_bus_lines_i,
  output logic [DATA_W-1:0] shared_bus_lines_o,
  output logic shared_bus_lines_oe_o,
  input wire logic ready_i,
  input wire logic supply_low_i
);
  // ----------------------------------------------------------------
  // strobe phase divider
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div_q, div_d;
  logic tick;
  assign tick = (div_q == DIV_W'(STROBE_CYC - 1));
  always_comb
  begin
    div_d = tick ? '0 : div_q + 1'b1;
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i) div_q <= '0;
    else div_q <= div_d;
  end

  // ----------------------------------------------------------------
  // read buffer
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] buf_mem_q [BUF_DEPTH];
  logic [DATA_W-1:0] buf_mem_d [BUF_DEPTH];
  logic [1:0] buf_cnt_q, buf_cnt_d;
  logic buf_wp_q, buf_wp_d, buf_rp_q, buf_rp_d;
  logic push, pop, buf_in_ready, buf_out_valid;
  assign buf_in_ready = (buf_cnt_q != 2'(BUF_DEPTH));
  assign buf_out_valid = (buf_cnt_q != 2'h0);
  always_comb
  begin
    buf_mem_d = buf_mem_q;
    buf_wp_d = buf_wp_q;
    buf_rp_d = buf_rp_q;
    if (push)
    begin
      buf_mem_d[buf_wp_q] = shared_bus_lines_i;
      buf_wp_d = ~buf_wp_q;
    end
    if (pop) buf_rp_d = ~buf_rp_q;
    buf_cnt_d = buf_cnt_q + 2'(push) - 2'(pop);
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < BUF_DEPTH; i++) buf_mem_q[i] <= '0;
      buf_cnt_q <= '0;
      buf_wp_q <= 1'b0;
      buf_rp_q <= 1'b0;
    end
    else
    begin
      buf_mem_q <= buf_mem_d;
      buf_cnt_q <= buf_cnt_d;
      buf_wp_q <= buf_wp_d;
      buf_rp_q <= buf_rp_d;
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave and control registers
  // ----------------------------------------------------------------
  logic [2:0] ctrl_q, ctrl_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic rst_seen_q, rst_seen_d, err_q, err_d;
  logic [2:0] acnt_q, acnt_d;
  logic [11:0] rcnt_q, rcnt_d;
  logic req, op_wr, op_take, op_refuse;
  logic [1:0] op_kind;
  logic [7:0] op_byte;
  nfhc_state_e st_q, st_d;
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign op_wr = req && wb_we_i && (wb_adr_i == REG_OP) && wb_sel_i[0] && wb_sel_i[1];
  assign op_kind = wb_dat_i[OP_KIND_LSB +: 2];
  assign op_byte = wb_dat_i[7:0];
  // commands other than reset are dropped until reset has been sent
  assign op_refuse = supply_low_i || (op_kind == OP_CMD && !rst_seen_q && op_byte != CMD_RESET);
  assign op_take = op_wr && (st_q == NF_IDLE) && !op_refuse;
  assign pop = req && !wb_we_i && (wb_adr_i == REG_RXD) && buf_out_valid;
  always_comb
  begin
    ctrl_d = ctrl_q;
    err_d = err_q;
    rst_seen_d = rst_seen_q;
    acnt_d = acnt_q;
    rcnt_d = rcnt_q;
    rdat_d = '0;
    // op writes wait for the engine, so the master is stalled
    ack_d = req && !(op_wr && st_q != NF_IDLE && !op_refuse);
    if (req && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0]) ctrl_d = wb_dat_i[2:0];
    if (req && wb_we_i && wb_adr_i == REG_STAT && wb_sel_i[0] && wb_dat_i[ST_ERR]) err_d = 1'b0;
    if (op_wr && op_refuse) err_d = 1'b1;
    if (op_take && op_kind == OP_CMD)
    begin
      if (op_byte == CMD_RESET) rst_seen_d = 1'b1;
      acnt_d = '0;
      rcnt_d = '0;
    end
    if (op_take && op_kind == OP_ADDR && acnt_q != 3'(ADDR_CYCLES)) acnt_d = acnt_q + 1'b1;
    if (push) rcnt_d = rcnt_q + 1'b1;
    if (req && !wb_we_i)
    begin
      case (wb_adr_i)
        REG_CTRL: rdat_d = {29'h0, ctrl_q};
        REG_STAT: rdat_d = {4'h0, rcnt_q, 5'h0, acnt_q, 3'h0, err_q, rst_seen_q,
                            buf_out_valid, ready_i, st_q != NF_IDLE};
        REG_RXD: rdat_d = {23'h0, buf_out_valid, buf_out_valid ? buf_mem_q[buf_rp_q] : 8'h00};
        default: rdat_d = '0;
      endcase
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_q <= CTRL_RST;
      ack_q <= 1'b0;
      rdat_q <= '0;
      err_q <= 1'b0;
      rst_seen_q <= 1'b0;
      acnt_q <= '0;
      rcnt_q <= '0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      err_q <= err_d;
      rst_seen_q <= rst_seen_d;
      acnt_q <= acnt_d;
      rcnt_q <= rcnt_d;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign write_protect_n_o = ctrl_q[CTRL_WPN];
  // must be set before the device powers up to take effect
  assign volatile_protect_input_o = ctrl_q[CTRL_VPE];

  // ----------------------------------------------------------------
  // pin sequencer
  // ----------------------------------------------------------------
  logic [1:0] kind_q, kind_d;
  logic [7:0] byte_q, byte_d;
  logic need_rdy, go;
  logic cle_q, cle_d, ale_q, ale_d, we_n_q, we_n_d, re_n_q, re_n_d, oe_q, oe_d, ce_n_q, ce_n_d;
  logic [DATA_W-1:0] dout_q, dout_d;
  // only reads, status and reset may go out while the device is busy
  assign need_rdy = !(kind_q == OP_READ || (kind_q == OP_CMD &&
                      (byte_q == CMD_RESET || byte_q == CMD_STATUS || byte_q == CMD_STATUS_ENH)));
  assign go = tick && (!need_rdy || ready_i) && (kind_q != OP_READ || buf_in_ready);
  assign push = (st_q == NF_RLOW) && tick;
  always_comb
  begin
    st_d = st_q;
    kind_d = kind_q;
    byte_d = byte_q;
    case (st_q)
      NF_IDLE:
        if (op_take)
        begin
          kind_d = op_kind;
          byte_d = op_byte;
          st_d = NF_WAIT;
        end
      NF_WAIT: if (go) st_d = (kind_q == OP_READ) ? NF_RLOW : NF_SETUP;
      NF_SETUP: if (tick) st_d = NF_HOLD;
      NF_HOLD: if (tick) st_d = NF_IDLE;
      NF_RLOW: if (tick) st_d = NF_RHIGH;
      NF_RHIGH: if (tick) st_d = NF_IDLE;
      default: st_d = NF_IDLE;
    endcase
    ce_n_d = !(ctrl_q[CTRL_CE] || st_d != NF_IDLE);
    we_n_d = (st_d != NF_SETUP);
    re_n_d = (st_d != NF_RLOW);
    oe_d = (st_d == NF_SETUP || st_d == NF_HOLD);
    cle_d = oe_d && kind_d == OP_CMD;
    ale_d = oe_d && kind_d == OP_ADDR;
    dout_d = oe_d ? byte_d : dout_q;
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= NF_IDLE;
      kind_q <= OP_CMD;
      byte_q <= '0;
      ce_n_q <= 1'b1;
      we_n_q <= 1'b1;
      re_n_q <= 1'b1;
      oe_q <= 1'b0;
      cle_q <= 1'b0;
      ale_q <= 1'b0;
      dout_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      kind_q <= kind_d;
      byte_q <= byte_d;
      ce_n_q <= ce_n_d;
      we_n_q <= we_n_d;
      re_n_q <= re_n_d;
      oe_q <= oe_d;
      cle_q <= cle_d;
      ale_q <= ale_d;
      dout_q <= dout_d;
    end
  end
  assign cle_o = cle_q;
  assign ale_o = ale_q;
  assign chip_sel_n_o = ce_n_q;
  assign write_strobe_n_o = we_n_q;
  assign read_strobe_n_o = re_n_q;
  assign shared_bus_lines_o = dout_q;
  assign shared_bus_lines_oe_o = oe_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  latch_excl_a: assert property (!(cle_q && ale_q)) else $error("both latches high");
  cmd_latch_a: assert property (!we_n_q |=> $stable(cle_q)) else $error("command latch moved under strobe");
  addr_latch_a: assert property (!we_n_q |=> $stable(ale_q)) else $error("address latch moved under strobe");
  data_hold_a: assert property ($rose(we_n_q) |-> oe_q && $stable(dout_q) ##1 $stable(dout_q))
    else $error("bus not held around write strobe rise");
  strobe_select_a: assert property ((!we_n_q || !re_n_q) |-> !ce_n_q) else $error("strobe without chip select");
  read_float_a: assert property (!re_n_q |-> !oe_q) else $error("host drives bus during read");
  read_count_a: assert property ($rose(re_n_q) |-> rcnt_q == $past(rcnt_q) + 12'h1) else $error("read count off");
  reset_first_a: assert property ($fell(we_n_q) && cle_q && dout_q != CMD_RESET |-> rst_seen_q)
    else $error("command before reset");
  busy_wait_a: assert property ($fell(we_n_q) && ale_q |-> $past(ready_i)) else $error("address sent while busy");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  write_len_a: assert property ($fell(we_n_q) |-> !we_n_q [*2] ##1 we_n_q) else $error("strobe width wrong");
  cmd_cov: cover property ($rose(we_n_q) && cle_q);
  addr_cov: cover property ($rose(we_n_q) && ale_q);
  read_cov: cover property ($rose(re_n_q));
  full_cov: cover property (buf_cnt_q == 2'h2);
endmodule
`default_nettype wire

// File: design/nfhc_pkg.sv
// Overview of operation
// - every written byte is latched on the write strobe's rising edge, and the host holds it steady around it.
// - the device is selected only while chip select is low; while busy it takes only reset and status commands.
// - after power-on the host issues the reset command before any other command.
// - commands, addresses and data share one 8-bit two-way bus, told apart by the latch strobes.
// - an address is five bus cycles, two column then three row, page bits before block bits.
package nfhc_pkg;
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned STROBE_NS = 50;
  localparam int unsigned STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DIV_W = 4;
  // register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OP = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_RXD = 8'h0c;
  // control fields
  localparam int unsigned CTRL_WPN = 0;
  localparam int unsigned CTRL_VPE = 1;
  localparam int unsigned CTRL_CE = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // op register: kind in [9:8], byte in [7:0]
  localparam int unsigned OP_KIND_LSB = 8;
  localparam logic [1:0] OP_CMD = 2'h0;
  localparam logic [1:0] OP_ADDR = 2'h1;
  localparam logic [1:0] OP_DATA = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;
  // status fields
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_RDY = 1;
  localparam int unsigned ST_RXV = 2;
  localparam int unsigned ST_RSTD = 3;
  localparam int unsigned ST_ERR = 4;
  localparam int unsigned ST_ACNT = 8;
  localparam int unsigned ST_RCNT = 16;
  // device commands
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
  // device geometry
  localparam int unsigned ADDR_CYCLES = 5;
  localparam int unsigned COL_CYCLES = 2;
  localparam int unsigned PLANE_SEL_BIT = 0;
  localparam int unsigned PAGE_MAIN = 2048;
  localparam int unsigned PAGE_SPARE = 128;
  localparam int unsigned BLOCK_PAGES = 64;
  localparam int unsigned PLANE_BLOCKS = 2048;
  typedef enum logic [2:0] {NF_IDLE, NF_WAIT, NF_SETUP, NF_HOLD, NF_RLOW, NF_RHIGH} nfhc_state_e;
endpackage
